//--- core/mf_digit_receiver.v
// Multi-frequency tone digit receiver with start and stop gating
`timescale 1ns/1ns
`include "mf_digit_receiver_defines.vh"
module mf_digit_receiver (
   // Clock and reset
   input  wire       mclk,
   input  wire       resetn,
   // Companded sample stream, one strobe per 8 kHz sample
   input  wire [7:0] sample_code,
   input  wire       sample_valid,
   // Digit report
   output reg  [3:0] digit_code_reg,
   output reg        digit_strobe_reg,
   // Status
   output wire       unlocked,
   output wire       tone_present,
   output reg        multi_tone_reg
);

   localparam [1:0] ST_LOCKED   = 2'b01;
   localparam [1:0] ST_UNLOCKED = 2'b10;

   // Expander output
   wire signed [15:0] lin;
   wire               lin_valid;

   // Frame bookkeeping
   reg  [5:0]  samp_cnt_reg;
   reg         frame_end_reg;
   reg  [5:0]  mask_reg;
   reg         mask_stb_reg;

   // Per-tone filter state and frame energies
   reg  signed [23:0] s1_reg [0:5];
   reg  signed [23:0] s2_reg [0:5];
   wire signed [47:0] energy [0:5];
   reg  [47:0]        emax;
   reg  [5:0]         valid_mask;
   integer            k;

   // Symbol tracking
   reg  [3:0]  cur_code;
   reg  [3:0]  track_code_reg;
   reg  [3:0]  run_cnt_reg;
   reg  [2:0]  gap_cnt_reg;
   reg         reported_reg;
   reg  [1:0]  state_reg;
   wire        accept;
   wire        is_stop;

   // Coefficient lookup by tone index
   function [15:0] coef_of;
      input integer idx;
      begin
         case (idx)
            0:       coef_of = `COEF_700;
            1:       coef_of = `COEF_900;
            2:       coef_of = `COEF_1100;
            3:       coef_of = `COEF_1300;
            4:       coef_of = `COEF_1500;
            default: coef_of = `COEF_1700;
         endcase
      end
   endfunction

   // Number of tones present in a mask
   function [2:0] tone_count;
      input [5:0] m;
      begin
         tone_count = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]}
                    + {2'b00, m[3]} + {2'b00, m[4]} + {2'b00, m[5]};
      end
   endfunction

   // Tone pair to symbol code
   function [3:0] pair_code;
      input [5:0] m;
      begin
         case (m)
            `MASK_D1:   pair_code = 4'h1;
            `MASK_D2:   pair_code = 4'h2;
            `MASK_D3:   pair_code = 4'h3;
            `MASK_D4:   pair_code = 4'h4;
            `MASK_D5:   pair_code = 4'h5;
            `MASK_D6:   pair_code = 4'h6;
            `MASK_D7:   pair_code = 4'h7;
            `MASK_D8:   pair_code = 4'h8;
            `MASK_D9:   pair_code = 4'h9;
            `MASK_D0:   pair_code = `CODE_D0;
            `MASK_KP:   pair_code = `CODE_KP;
            `MASK_ST:   pair_code = `CODE_ST;
            `MASK_STP:  pair_code = `CODE_STP;
            `MASK_ST2P: pair_code = `CODE_ST2P;
            `MASK_ST3P: pair_code = `CODE_ST3P;
            default:    pair_code = `CODE_NONE;
         endcase
      end
   endfunction

   mulaw_expander u_expander (
      .mclk          (mclk),
      .resetn        (resetn),
      .code_in       (sample_code),
      .code_valid    (sample_valid),
      .lin_reg       (lin),
      .lin_valid_reg (lin_valid)
   );

   // Sample counter marks the end of each analysis frame
   always @(posedge mclk) begin
      if (!resetn) begin
         samp_cnt_reg  <= 6'h00;
         frame_end_reg <= 1'b0;
      end else begin
         frame_end_reg <= 1'b0;
         if (lin_valid) begin
            if (samp_cnt_reg == `FRAME_SAMPLES - 1) begin
               samp_cnt_reg  <= 6'h00;
               frame_end_reg <= 1'b1;
            end else begin
               samp_cnt_reg <= samp_cnt_reg + 6'h01;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_tone
         wire signed [15:0] coef;
         wire signed [39:0] prod;
         wire signed [23:0] fb;
         wire signed [47:0] q1;
         wire signed [47:0] q2;
         wire signed [47:0] q3;

         assign coef = coef_of(g);
         assign prod = coef * s1_reg[g];
         assign fb   = prod[37:14];
         assign q1   = s1_reg[g] * s1_reg[g];
         assign q2   = s2_reg[g] * s2_reg[g];
         assign q3   = fb * s2_reg[g];
         // frame length sets the pass band around each tone
         assign energy[g] = q1 + q2 - q3;

         // Resonator update per sample, cleared after the frame is judged
         always @(posedge mclk) begin
            if (!resetn || frame_end_reg) begin
               s1_reg[g] <= 24'h000000;
               s2_reg[g] <= 24'h000000;
            end else if (lin_valid) begin
               s1_reg[g] <= {{8{lin[15]}}, lin} + fb - s2_reg[g];
               s2_reg[g] <= s1_reg[g];
            end
         end
      end
   endgenerate

   // Level and twist qualification of each tone
   always @* begin
      emax = 48'h0000_0000_0000;
      for (k = 0; k < 6; k = k + 1) begin
         if (energy[k] > $signed(emax)) begin
            emax = energy[k];
         end
      end
      for (k = 0; k < 6; k = k + 1) begin
         // absolute level threshold between -25 and -35 dBm0
         // twist window relative to the strongest tone
         // weak products fall under the relative floor
         valid_mask[k] = (energy[k] > $signed(`LEVEL_THR))
                      && (({energy[k][44:0], 3'b000} >> (3 - `TWIST_SHIFT)) >= emax);
      end
   end

   // Frame result capture
   always @(posedge mclk) begin
      if (!resetn) begin
         mask_reg       <= 6'h00;
         mask_stb_reg   <= 1'b0;
         multi_tone_reg <= 1'b0;
      end else begin
         mask_stb_reg <= frame_end_reg;
         if (frame_end_reg) begin
            mask_reg       <= valid_mask;
            // flag frames holding more than two tones
            multi_tone_reg <= (tone_count(valid_mask) > 3'h2);
         end
      end
   end

   // only exactly two tones form a symbol
   always @* begin
      if (tone_count(mask_reg) == 3'h2) begin
         cur_code = pair_code(mask_reg);
      end else begin
         cur_code = `CODE_NONE;
      end
   end

   // digit needs enough frames; longer run for KP
   assign accept = !reported_reg && (track_code_reg != `CODE_NONE)
                && (run_cnt_reg >= ((track_code_reg == `CODE_KP) ? `KP_FRAMES : `SIG_FRAMES));
   assign is_stop = (track_code_reg == `CODE_ST) || (track_code_reg == `CODE_STP)
                 || (track_code_reg == `CODE_ST2P) || (track_code_reg == `CODE_ST3P);
   assign tone_present = (track_code_reg != `CODE_NONE);

   // Tone run tracking with dropout bridging
   always @(posedge mclk) begin
      if (!resetn) begin
         track_code_reg <= `CODE_NONE;
         run_cnt_reg    <= 4'h0;
         gap_cnt_reg    <= 3'h0;
         reported_reg   <= 1'b0;
      end else if (mask_stb_reg) begin
         if (track_code_reg == `CODE_NONE) begin
            if (cur_code != `CODE_NONE) begin
               track_code_reg <= cur_code;
               run_cnt_reg    <= 4'h1;
               gap_cnt_reg    <= 3'h0;
               reported_reg   <= 1'b0;
            end
         // offset edges only spoil one frame of the run
         end else if (cur_code == track_code_reg) begin
            // coincident frames build the run count
            if (run_cnt_reg != 4'hF) begin
               run_cnt_reg <= run_cnt_reg + 4'h1;
            end
            gap_cnt_reg <= 3'h0;
         // short dropouts keep the tone alive
         end else if (gap_cnt_reg < `BRIDGE_FRAMES) begin
            gap_cnt_reg <= gap_cnt_reg + 3'h1;
         end else begin
            // tone has ended, a new report is allowed
            // off time is short enough for ten signals a second
            track_code_reg <= `CODE_NONE;
            run_cnt_reg    <= 4'h0;
            gap_cnt_reg    <= 3'h0;
            reported_reg   <= 1'b0;
         end
      end else if (accept) begin
         reported_reg <= 1'b1;
      end
   end

   // full-frame integration rejects noise before timing is judged
   // Lock state machine and digit reporting
   always @(posedge mclk) begin
      if (!resetn) begin
         // reset lands in the locked state
         state_reg        <= ST_LOCKED;
         digit_code_reg   <= `CODE_NONE;
         digit_strobe_reg <= 1'b0;
      end else begin
         digit_strobe_reg <= 1'b0;
         case (state_reg)
            ST_LOCKED: begin
               // only KP leaves the locked state
               if (accept && (track_code_reg == `CODE_KP)) begin
                  state_reg        <= ST_UNLOCKED;
                  digit_code_reg   <= track_code_reg;
                  digit_strobe_reg <= 1'b1;
               end
            end
            ST_UNLOCKED: begin
               // repeated KP is neither reported nor restarts
               if (accept && (track_code_reg != `CODE_KP)) begin
                  // report digits until a stop signal
                  digit_code_reg   <= track_code_reg;
                  digit_strobe_reg <= 1'b1;
                  if (is_stop) begin
                     state_reg <= ST_LOCKED;
                  end
               end
            end
            default: begin
               state_reg <= ST_LOCKED;
            end
         endcase
      end
   end

   assign unlocked = state_reg[1];

endmodule // mf_digit_receiver

//--- core/mf_digit_receiver_defines.vh
// Constants for the multi-frequency tone digit receiver
`ifndef MF_DIGIT_RECEIVER_DEFINES_VH
`define MF_DIGIT_RECEIVER_DEFINES_VH

// Sampling and analysis frame
`define SAMPLE_RATE_HZ   8000
`define FRAME_SAMPLES    40
`define FRAME_US         ((`FRAME_SAMPLES * 1000000) / `SAMPLE_RATE_HZ)

// Timing windows, in milliseconds, and their frame counts
`define SIG_ACCEPT_MS    20
`define KP_ACCEPT_MS     35
`define BRIDGE_MS        15
`define SIG_FRAMES       ((`SIG_ACCEPT_MS * 1000) / `FRAME_US)
`define KP_FRAMES        ((`KP_ACCEPT_MS * 1000) / `FRAME_US)
`define BRIDGE_FRAMES    ((`BRIDGE_MS * 1000) / `FRAME_US)

// Detection thresholds
`define LEVEL_THR        48'h0000_0BDC_0000
`define TWIST_SHIFT      3

// Goertzel coefficients, 2cos(2*pi*f/fs) in Q14
`define COEF_700         16'h6D23
`define COEF_900         16'h6155
`define COEF_1100        16'h5321
`define COEF_1300        16'h42E1
`define COEF_1500        16'h30FC
`define COEF_1700        16'h1DE1

// Tone masks, bit0 = 700 Hz up to bit5 = 1700 Hz
`define MASK_D1          6'h03
`define MASK_D2          6'h05
`define MASK_D3          6'h06
`define MASK_D4          6'h09
`define MASK_D5          6'h0A
`define MASK_D6          6'h0C
`define MASK_D7          6'h11
`define MASK_D8          6'h12
`define MASK_D9          6'h14
`define MASK_D0          6'h18
`define MASK_KP          6'h24
`define MASK_ST          6'h30
`define MASK_STP         6'h22
`define MASK_ST2P        6'h28
`define MASK_ST3P        6'h21

// Reported symbol codes
`define CODE_NONE        4'h0
`define CODE_D0          4'hA
`define CODE_KP          4'hB
`define CODE_ST          4'hC
`define CODE_STP         4'hD
`define CODE_ST2P        4'hE
`define CODE_ST3P        4'hF

`endif

//--- core/mulaw_expander.v
// Companded sample expander to 16-bit linear
`timescale 1ns/1ns
module mulaw_expander (
   // Clock and reset
   input  wire               mclk,
   input  wire               resetn,
   // Companded input
   input  wire [7:0]         code_in,
   input  wire               code_valid,
   // Linear output
   output reg  signed [15:0] lin_reg,
   output reg                lin_valid_reg
);

   wire [7:0]  inv;
   wire [15:0] mag;

   // Segment and step decode, bias removed
   assign inv = ~code_in;
   assign mag = ((({11'h000, inv[3:0], 1'b0} << 2) + 16'h0084) << inv[6:4]) - 16'h0084;

   // Registered expansion with sign applied
   always @(posedge mclk) begin
      if (!resetn) begin
         lin_reg       <= 16'h0000;
         lin_valid_reg <= 1'b0;
      end else begin
         lin_valid_reg <= code_valid;
         if (code_valid) begin
            lin_reg <= inv[7] ? -$signed(mag) : $signed(mag);
         end
      end
   end

endmodule // mulaw_expander

//--- tb/mf_digit_receiver_asserts.sv
// Port checker for the tone digit receiver
`timescale 1ns/1ns
`include "mf_digit_receiver_defines.vh"
module mf_digit_receiver_asserts (
   // Clock and reset
   input wire       mclk,
   input wire       resetn,
   // Sample input
   input wire [7:0] sample_code,
   input wire       sample_valid,
   // Watched outputs
   input wire [3:0] digit_code_reg,
   input wire       digit_strobe_reg,
   input wire       unlocked,
   input wire       tone_present,
   input wire       multi_tone_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_reset_clear: assert property (disable iff (1'b0)
      !resetn |=> !digit_strobe_reg && !unlocked && !tone_present && digit_code_reg == 4'h0)
      else $error("outputs not cleared by reset");
   a_strobe_pulse: assert property (
      digit_strobe_reg |=> !digit_strobe_reg [*8]) else $error("strobe not a lone pulse");
   a_code_hold: assert property (
      !digit_strobe_reg |-> $stable(digit_code_reg)) else $error("code moved without strobe");
   a_kp_unlock: assert property (
      $rose(unlocked) |-> digit_strobe_reg && digit_code_reg == `CODE_KP)
      else $error("unlocked without start report");
   a_locked_kp_only: assert property (
      digit_strobe_reg && !$past(unlocked) |-> digit_code_reg == `CODE_KP)
      else $error("report while locked");
   a_kp_ignored: assert property (
      digit_strobe_reg && $past(unlocked) |-> digit_code_reg != `CODE_KP)
      else $error("second start reported");
   a_stop_relock: assert property (
      digit_strobe_reg && digit_code_reg >= `CODE_ST |-> !unlocked)
      else $error("stop did not relock");
   a_unlock_drop: assert property (
      $fell(unlocked) |-> digit_strobe_reg && digit_code_reg >= `CODE_ST)
      else $error("relocked without stop");
   a_multi_silent: assert property (
      digit_strobe_reg |-> !multi_tone_reg) else $error("report during three tones");
   a_report_tracked: assert property (
      digit_strobe_reg |-> $past(tone_present)) else $error("report without tracked pair");
   a_code_valid: assert property (
      digit_strobe_reg |-> digit_code_reg != `CODE_NONE) else $error("empty code reported");

   // Main scenarios reached
   c_start: cover property (digit_strobe_reg && digit_code_reg == `CODE_KP);
   c_relock: cover property ($fell(unlocked));
   c_multi: cover property ($rose(multi_tone_reg));
   c_track: cover property ($rose(tone_present));
endmodule // mf_digit_receiver_asserts

bind mf_digit_receiver mf_digit_receiver_asserts chk_u (.mclk, .resetn, .sample_code,
   .sample_valid, .digit_code_reg, .digit_strobe_reg, .unlocked, .tone_present,
   .multi_tone_reg);

//--- tb/mf_digit_receiver_test.sv
// Self-checking bench for the tone digit receiver
`timescale 1ns/1ns
`include "mf_digit_receiver_defines.vh"
module mf_digit_receiver_test;
   localparam int MS = 32;   // Cycles per ms of sample time at 4 cycles a sample
   logic       mclk;
   logic       resetn;
   logic [7:0] sample_code;
   logic       sample_valid;
   wire  [3:0] digit_code_reg;
   wire        digit_strobe_reg;
   wire        unlocked;
   wire        tone_present;
   wire        multi_tone_reg;
   int         f_a = 0;
   int         f_b = 0;
   int         f_c = 0;
   int         db_a = -10;
   int         db_b = -10;
   int         err_total = 0;
   int         n_compared = 0;
   int         n_strobe = 0;
   int         cyc = 0;
   int         n0;
   logic [3:0] last_code = 4'h0;
   int         lo[10] = '{0, 0, 1, 0, 1, 2, 0, 1, 2, 3};
   int         hi[10] = '{1, 2, 2, 3, 3, 3, 4, 4, 4, 4};
   int         st_lo[4] = '{4, 1, 3, 0};

   mf_tone_source #(.GAP(4)) src_u (.mclk, .resetn, .f_a, .f_b, .f_c, .db_a, .db_b,
      .sample_code, .sample_valid);
   mf_digit_receiver dut_u (.mclk, .resetn, .sample_code, .sample_valid, .digit_code_reg,
      .digit_strobe_reg, .unlocked, .tone_present, .multi_tone_reg);

   // Clock of 50 ns
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Report monitor and hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (digit_strobe_reg === 1'b1) begin
         n_strobe <= n_strobe + 1;
         last_code <= digit_code_reg;
      end
      if (cyc == 90000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Tone on for on_ms, then silence for off_ms
   task automatic play(input int fa, fb, fc, da, db, on_ms, off_ms);
      f_a = fa;
      f_b = fb;
      f_c = fc;
      db_a = da;
      db_b = db;
      repeat (on_ms * MS) @(posedge mclk);
      #1 f_a = 0;
      f_b = 0;
      f_c = 0;
      repeat (off_ms * MS) @(posedge mclk);
      #1;
   endtask

   task automatic t_start;
      play(900, 1300, 0, -10, -10, 40, 30);
      check("early strobes", n_strobe, 0);
      check("unlocked", unlocked, 0);
      play(1100, 1700, 0, -10, -10, 100, 30);
      check("strobes", n_strobe, 1);
      check("code", last_code, `CODE_KP);
      check("unlocked", unlocked, 1);
      play(1100, 1700, 0, -10, -10, 100, 30);
      check("repeat start", n_strobe, 1);
      check("still unlocked", unlocked, 1);
      $display("test start done");
   endtask

   task automatic t_digits;
      n0 = n_strobe;
      for (int i = 0; i < 10; i++) begin
         play(700 + 200 * lo[i], 700 + 200 * hi[i], 0, -10, -10, 40, 30);
         check("digit count", n_strobe - n0, i + 1);
         check("digit code", last_code, (i == 9) ? `CODE_D0 : i + 1);
      end
      $display("test digits done");
   endtask

   task automatic t_windows;
      n0 = n_strobe;
      play(700, 900, 0, -10, -10, 5, 30);
      check("short", n_strobe - n0, 0);
      play(700, 900, 0, -10, -10, 30, 5);
      play(700, 900, 0, -10, -10, 30, 30);
      check("bridged", n_strobe - n0, 1);
      play(700, 900, 1100, -10, -10, 40, 0);
      check("multi flag", multi_tone_reg, 1);
      check("no pair", tone_present, 0);
      repeat (30 * MS) @(posedge mclk);
      #1;
      check("multi clear", multi_tone_reg, 0);
      check("three tones", n_strobe - n0, 1);
      play(900, 1300, 0, -35, -35, 40, 30);
      check("weak", n_strobe - n0, 1);
      play(900, 1300, 0, -25, -25, 40, 30);
      check("faint", n_strobe - n0, 2);
      play(918, 1324, 0, -10, -10, 40, 30);
      check("offset", n_strobe - n0, 3);
      play(900, 1300, 0, -10, -16, 40, 0);
      check("pair held", tone_present, 1);
      repeat (30 * MS) @(posedge mclk);
      #1;
      check("pair ended", tone_present, 0);
      check("twist", n_strobe - n0, 4);
      check("twist code", last_code, 4'h5);
      $display("test windows done");
   endtask

   // Skewed tone start and short or long coincidence, while unlocked
   task automatic t_timing;
      n0 = n_strobe;
      db_a = -10;
      f_a = 700;
      repeat (3 * MS) @(posedge mclk);
      #1;
      play(700, 900, 0, -10, -10, 40, 30);
      check("skewed start", n_strobe - n0, 1);
      play(700, 900, 0, -10, -10, 8, 30);
      check("short overlap", n_strobe - n0, 1);
      play(700, 900, 0, -10, -10, 26, 30);
      check("long overlap", n_strobe - n0, 2);
      $display("test timing done");
   endtask

   task automatic t_stops;
      for (int i = 0; i < 4; i++) begin
         play(700 + 200 * st_lo[i], 1700, 0, -10, -10, 40, 30);
         check("stop code", last_code, `CODE_ST + i);
         check("unlocked", unlocked, 0);
         play(1100, 1700, 0, -10, -10, 60, 30);
         check("start code", last_code, `CODE_KP);
         check("unlocked again", unlocked, 1);
      end
      play(1100, 1700, 0, -10, -10, 60, 30);
      resetn = 1'b0;
      repeat (8) @(posedge mclk);
      #1 resetn = 1'b1;
      check("unlocked", unlocked, 0);
      n0 = n_strobe;
      play(700, 900, 0, -10, -10, 40, 30);
      check("relocked", n_strobe - n0, 0);
      $display("test stops done");
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      repeat (8) @(posedge mclk);
      #1 resetn = 1'b1;
      t_start();
      t_digits();
      t_windows();
      t_timing();
      t_stops();
      give_verdict();
   end
endmodule // mf_digit_receiver_test

//--- tb/mf_tone_source.sv
// Trunk model sending tone pairs as companded samples
`timescale 1ns/1ns
module mf_tone_source #(
   parameter int GAP = 4
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               resetn,
   // Tone control, a frequency of 0 is silent
   input  wire logic signed [31:0] f_a,
   input  wire logic signed [31:0] f_b,
   input  wire logic signed [31:0] f_c,
   input  wire logic signed [31:0] db_a,
   input  wire logic signed [31:0] db_b,
   // Companded sample stream
   output logic [7:0]              sample_code,
   output logic                    sample_valid
);
   int  n = 0;
   int  cnt = 0;
   real v;

   // One sine component at a level in dBm0
   function automatic real tone(input int f, input int db);
      if (f == 0)
         return 0.0;
      return 22700.0 * $pow(10.0, db / 20.0) * $sin(6.2831853 * f * n / 8000.0);
   endfunction

   function automatic logic [7:0] enc(input int x);
      int   m;
      int   e;
      logic s;
      s = x < 0;
      m = s ? -x : x;
      if (m > 32635)
         m = 32635;
      m = m + 132;
      e = 7;
      while (e > 0 && m < (128 << e))
         e--;
      return ~{s, 3'(e), 4'(m >> (e + 3))};
   endfunction

   // One sample every GAP cycles; released line shows the inverse
   initial begin
      sample_valid = 1'b0;
      sample_code  = 8'hFF;
      forever begin
         @(posedge mclk);
         #2;
         if (resetn && cnt == GAP - 1) begin
            v = tone(f_a, db_a) + tone(f_b, db_b) + tone(f_c, db_a);
            sample_code = enc(int'(v));
            sample_valid = 1'b1;
            n++;
            cnt = 0;
         end else begin
            if (sample_valid)
               sample_code = ~sample_code;
            sample_valid = 1'b0;
            cnt = resetn ? cnt + 1 : 0;
         end
      end
   end
endmodule // mf_tone_source
